// ### inc/bas_defines.vh
`ifndef BAS_DEFINES_VH
`define BAS_DEFINES_VH

// Register byte offsets
`define BAS_CONFIG_OFS      4'h0
`define BAS_STATUS_OFS      4'h4
`define BAS_ADDR_OFS        4'h8
`define BAS_START_OFS       4'hC

// Config field positions
`define BAS_LEN_LSB         0
`define BAS_LEN_MSB         1
`define BAS_HYB_BIT         2
// Config reset: legacy wrap, 32-byte group
`define BAS_CONFIG_RST      3'h7

// Wrap length field codes
`define BAS_LEN_128         2'h0
`define BAS_LEN_64          2'h1
`define BAS_LEN_16          2'h2
`define BAS_LEN_32          2'h3

// Word index masks per group (16-bit words)
`define BAS_MASK_128        7'h3F
`define BAS_MASK_64         7'h1F
`define BAS_MASK_16         7'h07
`define BAS_MASK_32         7'h0F

// Status field positions
`define BAS_ST_ACTIVE       0
`define BAS_ST_LINEAR       1
`define BAS_ST_WRAPDONE     2

// AXI responses
`define BAS_RESP_OKAY       2'h0
`define BAS_RESP_SLVERR     2'h2

`endif

// ### src/bas_burst_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "bas_defines.vh"

module bas_burst_sequencer #(
  parameter AW = 22                       // Word address width
) (
  input  wire          aclk,              // System clock
  input  wire          aresetn,           // Synchronous reset, low active
  // AXI4-Lite slave
  input  wire [3:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [3:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // Link pins
  input  wire          link_ck,           // Bus clock pin, sampled
  input  wire          link_cs_n,         // Chip select pin, low active
  // From command-address decoder (aclk domain)
  input  wire          ca_load,           // One-cycle pulse: start burst
  input  wire [AW-1:0] ca_word_addr,      // Starting word address
  input  wire          ca_linear,         // Linear burst requested
  // Sequencer outputs
  output reg  [AW-1:0] burst_addr,        // Current word address
  output reg           burst_active,      // Burst in progress
  output reg           burst_step         // Pulse: address advanced
);

  // Group mask from the wrap length code
  function [6:0] len_mask;
    input [1:0] code;
    begin
      case (code)
        `BAS_LEN_128: len_mask = `BAS_MASK_128;
        `BAS_LEN_64:  len_mask = `BAS_MASK_64;
        `BAS_LEN_16:  len_mask = `BAS_MASK_16;
        default:      len_mask = `BAS_MASK_32;
      endcase
    end
  endfunction

  // Pin synchronisers, two stages each
  reg            ck_s1;                   // Link clock first stage
  reg            ck_s2;                   // Link clock second stage
  reg            ck_prev;                 // For edge detect
  reg            cs_s1;                   // Chip select first stage
  reg            cs_s2;                   // Chip select second stage

  // Configuration and burst state
  reg  [2:0]     primary_config_register; // Hybrid bit and length field
  reg  [AW-1:0]  start_addr;              // Latched start word
  reg  [6:0]     grp_mask;                // Latched group mask
  reg            hyb_mode;                // Latched: hybrid wrap chosen
  reg            lin_mode;                // Now incrementing linearly
  reg            wrap_done;               // Hybrid wrap finished
  reg  [6:0]     wrap_cnt;                // Words issued in the wrap

  wire           hybrid_wrap_select_bit = primary_config_register[`BAS_HYB_BIT];
  wire [1:0]     wrap_length_field =
                   primary_config_register[`BAS_LEN_MSB:`BAS_LEN_LSB];
  wire           ck_rise = ck_s2 & ~ck_prev;
  wire [AW-1:0]  mask_w  = {{(AW-7){1'b0}}, grp_mask};

  // Synchronise the link pins
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ck_s1   <= 1'b0;
      ck_s2   <= 1'b0;
      ck_prev <= 1'b0;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
    end
    else
    begin
      ck_s1   <= link_ck;
      ck_s2   <= ck_s1;
      ck_prev <= ck_s2;
      cs_s1   <= link_cs_n;
      cs_s2   <= cs_s1;
    end
  end

  // Next address logic
  reg  [AW-1:0]  next_addr;
  reg            next_lin;
  reg            next_done;
  reg  [AW-1:0]  grp_base;
  always @*
  begin
    grp_base  = burst_addr & ~mask_w;
    next_addr = burst_addr + {{(AW-1){1'b0}}, 1'b1};
    next_lin  = lin_mode;
    next_done = wrap_done;
    if (lin_mode)
    begin
      next_addr = burst_addr + {{(AW-1){1'b0}}, 1'b1};
    end
    else if (hyb_mode && (wrap_cnt == grp_mask))
    begin
      next_addr = (start_addr & ~mask_w) + mask_w + {{(AW-1){1'b0}}, 1'b1};
      next_lin  = 1'b1;
      next_done = 1'b1;
    end
    else
    begin
      next_addr = grp_base | ((burst_addr + {{(AW-1){1'b0}}, 1'b1}) & mask_w);
    end
  end

  // Burst sequencer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      burst_addr   <= {AW{1'b0}};
      burst_active <= 1'b0;
      burst_step   <= 1'b0;
      start_addr   <= {AW{1'b0}};
      grp_mask     <= `BAS_MASK_32;
      hyb_mode     <= 1'b0;
      lin_mode     <= 1'b0;
      wrap_done    <= 1'b0;
      wrap_cnt     <= 7'h00;
    end
    else
    begin
      burst_step <= 1'b0;
      if (cs_s2)
      begin
        burst_active <= 1'b0;
      end
      else if (ca_load)
      begin
        // Settings latched so mid-burst writes cannot tear it
        burst_active <= 1'b1;
        burst_addr   <= ca_word_addr;
        start_addr   <= ca_word_addr;
        grp_mask     <= len_mask(wrap_length_field);
        hyb_mode     <= ~hybrid_wrap_select_bit;
        lin_mode     <= ca_linear;
        wrap_done    <= 1'b0;
        wrap_cnt     <= 7'h00;
      end
      else if (burst_active && ck_rise)
      begin
        burst_addr <= next_addr;
        lin_mode   <= next_lin;
        wrap_done  <= next_done;
        wrap_cnt   <= wrap_cnt + 7'h01;
        burst_step <= 1'b1;
      end
    end
  end

  // AXI write channel state
  reg            aw_held;                 // Write address captured
  reg            w_held;                  // Write data captured
  reg  [3:0]     aw_addr;                 // Held write address
  reg  [31:0]    w_data;                  // Held write data
  reg  [3:0]     w_strb;                  // Held byte enables

  // Ready while nothing held and no response pending
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire           aw_go = aw_held | s_axi_awvalid;
  wire           w_go  = w_held | s_axi_wvalid;
  wire [3:0]     wa    = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0]    wd    = w_held ? w_data : s_axi_wdata;
  wire [3:0]     ws    = w_held ? w_strb : s_axi_wstrb;
  wire           wr_do = aw_go & w_go & ~s_axi_bvalid;

  // Write path and config register
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held                 <= 1'b0;
      w_held                  <= 1'b0;
      aw_addr                 <= 4'h0;
      w_data                  <= 32'h00000000;
      w_strb                  <= 4'h0;
      s_axi_bvalid            <= 1'b0;
      s_axi_bresp             <= `BAS_RESP_OKAY;
      primary_config_register <= `BAS_CONFIG_RST;
    end
    else
    begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_do)
      begin
        // Both halves present: commit and answer
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wa == `BAS_CONFIG_OFS)
        begin
          s_axi_bresp <= `BAS_RESP_OKAY;
          if (ws[0])
            primary_config_register <= wd[2:0];
        end
        else if (wa == `BAS_STATUS_OFS || wa == `BAS_ADDR_OFS ||
                 wa == `BAS_START_OFS)
          // Read-only registers ignore writes
          s_axi_bresp <= `BAS_RESP_OKAY;
        else
          s_axi_bresp <= `BAS_RESP_SLVERR;
      end
      else
      begin
        // Capture whichever half arrives first
        if (s_axi_awvalid && s_axi_awready)
        begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
      end
    end
  end

  // Read mux, zero above used bits
  reg  [31:0]    rd_mux;
  reg            rd_err;
  always @*
  begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (s_axi_araddr)
      `BAS_CONFIG_OFS: rd_mux = {29'h00000000, primary_config_register};
      `BAS_STATUS_OFS: rd_mux = {29'h00000000, wrap_done, lin_mode, burst_active};
      `BAS_ADDR_OFS:   rd_mux = {{(32-AW){1'b0}}, burst_addr};
      `BAS_START_OFS:  rd_mux = {{(32-AW){1'b0}}, start_addr};
      default:         rd_err = 1'b1;
    endcase
  end

  // Read path, one cycle answer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `BAS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_err ? `BAS_RESP_SLVERR : `BAS_RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // bas_burst_sequencer

`default_nettype wire

// ### verif/bas_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bas_host_model (
  output logic link_ck,   // Link clock, still outside frames
  output logic link_cs_n  // Chip select, low active
);
  // Idle link at time zero
  initial
  begin
    link_ck = 1'h0;
    link_cs_n = 1'h1;
  end
  task automatic frame(input bit on);
    #13 link_cs_n = !on;
  endtask
  // Off-phase period, one word each
  task automatic tick();
    #7 link_ck = 1'h1;
    #100 link_ck = 1'h0;
    #93;
  endtask
endmodule // bas_host_model
`default_nettype wire

// ### verif/bas_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module bas_seq_properties #(
  parameter AW = 22
) (
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          ca_load,
  input wire logic          ca_linear,
  input wire logic [AW-1:0] ca_word_addr,
  input wire logic          link_cs_n,
  input wire logic [AW-1:0] burst_addr,
  input wire logic          burst_active,
  input wire logic          burst_step,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready
);
  logic          lin;   // Linear burst in force
  logic [AW-1:0] prev;  // Address one cycle back
  // Track burst kind and last address
  always @(posedge aclk)
  begin
    prev <= burst_addr;
    if (!aresetn)
      lin <= 1'h0;
    else if (ca_load)
      lin <= ca_linear;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Select held low past the synchroniser
  sequence cs_low3;
    !link_cs_n [*3];
  endsequence
  load_start_a: assert property (cs_low3 ##0 ca_load |=> burst_active
    && burst_addr == $past(ca_word_addr)) else $error("burst start wrong");
  lin_step_a: assert property (lin && burst_step && !$past(ca_load)
    |-> burst_addr == prev + 1'h1) else $error("linear step wrong");
  wrap_back_a: assert property (!lin && burst_step && !$past(ca_load)
    && burst_addr != prev + 1'h1 |-> burst_addr[2:0] == 3'h0
    && (burst_addr > prev || prev[2:0] == 3'h7)) else $error("bad wrap jump");
  idle_step_a: assert property (!burst_active |-> !burst_step)
    else $error("step while idle");
  step_pulse_a: assert property (burst_step |=> !burst_step)
    else $error("step too long");
  move_step_a: assert property ($changed(burst_addr) && !$past(ca_load)
    |-> burst_step) else $error("silent address move");
  cs_end_a: assert property (link_cs_n [*5] |-> !burst_active)
    else $error("burst outlives select");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  wr_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
endmodule // bas_seq_properties
bind bas_burst_sequencer bas_seq_properties #(.AW(AW)) i_bas_seq_properties (.aclk,
  .aresetn, .ca_load, .ca_linear, .ca_word_addr, .link_cs_n, .burst_addr, .burst_active,
  .burst_step, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int AW = 22;
  logic          aclk = 0, aresetn = 0;
  logic [3:0]    s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic [31:0]   s_axi_wdata = 0, s_axi_rdata;
  logic          s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic          s_axi_arvalid = 0, s_axi_rready = 0, ca_load = 0, ca_linear = 0;
  logic [AW-1:0] ca_word_addr = 0, burst_addr;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic          link_ck, link_cs_n, burst_active, burst_step;
  int            fails = 0, compares = 0, cyc = 0;
  int            wtab [4] = '{64, 32, 8, 16};  // Words per length code
  always #12.5 aclk = ~aclk;
  bas_burst_sequencer #(.AW(AW)) i_bas_burst_sequencer (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .link_ck, .link_cs_n, .ca_load, .ca_word_addr,
    .ca_linear, .burst_addr, .burst_active, .burst_step);
  bas_host_model i_bas_host_model (.link_ck, .link_cs_n);
  // Hang guard, far above the few thousand cycles used
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Ready sampled mid-cycle, release after the taking edge
  task automatic axw(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s,
                     output logic [1:0] rs);
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(negedge aclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (aw)
        s_axi_awvalid <= 0;
      if (w)
        s_axi_wvalid <= 0;
    end
    while (!b);
    s_axi_bready <= 0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic ar, r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(negedge aclk);
      ar = s_axi_arready;
      r = s_axi_rvalid;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ar)
        s_axi_arvalid <= 0;
    end
    while (!r);
    s_axi_rready <= 0;
  endtask
  // Reference order: wrap in group, hybrid runs on past it
  function automatic int expa(int st, int n, int c, bit hyb, bit lin);
    int w;
    int b;
    w = wtab[c];
    b = st - st % w;
    if (lin)
      return st + n;
    if (hyb && n >= w)
      return b + n;
    return b + (st % w + n) % w;
  endfunction
  // Legacy codes, hybrid codes, then one linear burst
  initial
  begin
    int st, n, cfg;
    logic [31:0] d;
    logic [1:0] rs;
    void'($urandom(32'h3C7D));
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    axr(4'h0, d, rs);
    chk("cfg_reset", d, 32'h7);
    axr(4'h2, d, rs);
    chk("unmapped", {d[29:0], rs}, 32'h2);
    axw(4'h2, 32'h0, 4'hF, rs);
    chk("wr_unmapped", rs, 2'h2);
    axw(4'h0, 32'h0, 4'h0, rs);
    chk("wr_nostrb", rs, 2'h0);
    axr(4'h0, d, rs);
    chk("cfg_kept", d, 32'h7);
    $display("register test done");
    for (int i = 0; i < 9; i++)
    begin
      cfg = (i % 4) | ((i < 4) ? 4 : 0);
      st = (i == 2) ? 2 : $urandom % 32'h3FFF00;
      axw(4'h0, cfg, 4'hF, rs);
      chk("cfg_wr", rs, 2'h0);
      axr(4'h0, d, rs);
      chk("cfg_rd", d, cfg);
      i_bas_host_model.frame(1);
      repeat (4) @(posedge aclk);
      ca_word_addr <= st[AW-1:0];
      ca_linear <= (i == 8);
      ca_load <= 1;
      @(posedge aclk);
      ca_load <= 0;
      @(negedge aclk);
      chk("start", burst_addr, st);
      chk("active", burst_active, 1);
      for (n = 1; n <= wtab[cfg % 4] + 4; n++)
      begin
        i_bas_host_model.tick();
        chk("addr", burst_addr, expa(st, n, cfg % 4, cfg < 4, i == 8));
      end
      axr(4'h8, d, rs);
      chk("addr_reg", d, expa(st, n - 1, cfg % 4, cfg < 4, i == 8));
      axr(4'hC, d, rs);
      chk("start_reg", d, st);
      axr(4'h4, d, rs);
      chk("status", d, (i == 8) ? 3 : (cfg < 4) ? 7 : 1);
      i_bas_host_model.frame(0);
      repeat (6) @(posedge aclk);
      ca_word_addr <= ~st[AW-1:0];
      ca_load <= 1;
      @(posedge aclk);
      ca_load <= 0;
      @(negedge aclk);
      chk("ended", burst_active, 0);
      chk("held", burst_addr, expa(st, n - 1, cfg % 4, cfg < 4, i == 8));
      $display("burst test %0d done", i);
    end
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
